//--- common/mhcf_map.svh
// register offsets, field positions and reset values of the handler status bank
`ifndef MHCF_MAP_SVH
`define MHCF_MAP_SVH
`define MHCF_OFS_CONSTRAINT     12'h31c
`define MHCF_OFS_TXREQ_0_31     12'h320
`define MHCF_OFS_TXREQ_32_63    12'h324
`define MHCF_OFS_TXREQ_64_95    12'h328
`define MHCF_OFS_TXREQ_96_127   12'h32c
`define MHCF_OFS_IRQ_STATUS     12'h340
`define MHCF_OFS_IRQ_MASK       12'h344
`define MHCF_BIT_SKIP_A         0
`define MHCF_BIT_SKIP_B         1
`define MHCF_BIT_SEARCH_A       2
`define MHCF_BIT_SEARCH_B       3
`define MHCF_BIT_TRANS_A        4
`define MHCF_BIT_TRANS_B        5
`define MHCF_BIT_HDR_WR         8
`define MHCF_FLAG_MASK          32'h0000013f
`define MHCF_RST_CONSTRAINT     32'h00000000
`define MHCF_RST_TXREQ          128'h0
`define MHCF_NUM_BUF            128
`endif

//--- common/mhcf_pkg.sv
// types of the handler status bank
package mhcf_pkg;
   typedef struct packed {
      logic status_skip_chan_a;
      logic status_skip_chan_b;
      logic search_incomplete_chan_a;
      logic search_incomplete_chan_b;
      logic transient_access_fail_a;
      logic transient_access_fail_b;
      logic header_write_blocked;
   } mhcf_events_s;
   typedef struct packed {
      logic        wr;
      logic [6:0]  buf_idx;
      logic        hdr_target;
      logic [31:0] data;
   } mhcf_msg_wr_s;
   typedef enum logic [2:0] {
      MHCF_DEFAULT_CONFIG = 3'h1,
      MHCF_CONFIG         = 3'h2,
      MHCF_RUN            = 3'h4
   } mhcf_ctrl_e;
endpackage

//--- verilog/mhcf_status_bank.sv
// handler constraint flags, transmission request flags and interrupt
// Overview of operation
// [R1] writing one clears a constraint flag
// [R2] hard reset clears constraint flags
// [R3] config exit or bringup entry clears flags
// [R4] bit 0 channel A status skip
// [R5] bit 1 channel B status skip
// [R6] bit 2 channel A search incomplete
// [R7] bit 3 channel B search incomplete
// [R8] bit 4 channel A transient access fail
// [R9] bit 5 channel B transient access fail
// [R10] bit 8 header write, outside config states
// [R11] header partition writes are suppressed
// [R12] flag rising sets error irq handler flag
// [R13] 128 read-only send request flags
// [R14] single-shot flag clears after transmission
// [R15] flags act only for transmit buffers
// [R16] flags above configured buffers never send
// [R17] 32 flags per register, ascending
// [R18] unassigned bits read zero, writes ignored
`include "mhcf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mhcf_status_bank (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic [11:0]           reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [31:0]                reg_rdata,
   input  wire logic                  leave_config,
   input  wire logic                  enter_bringup,
   input  wire mhcf_pkg::mhcf_ctrl_e  ctrl_state,
   input  wire mhcf_pkg::mhcf_events_s evt,
   input  wire logic [127:0]          send_set,
   input  wire logic [127:0]          send_done,
   input  wire logic [127:0]          buf_is_tx,
   input  wire logic [127:0]          buf_single_shot,
   input  wire logic [7:0]            num_configured,
   output logic [127:0]               send_eligible,
   input  wire mhcf_pkg::mhcf_msg_wr_s msg_wr_in,
   output mhcf_pkg::mhcf_msg_wr_s     msg_wr_out,
   output logic                       error_irq_handler_flag,
   output logic                       irq
);
   logic [31:0]  cflags_q;
   logic [31:0]  cflags_d;
   logic [127:0] send_request_flag_q;
   logic [127:0] send_d;
   logic [1:0]   ists_q;
   logic [1:0]   ists_d;
   logic [1:0]   imask_q;
   logic [31:0]  rdata_q;
   logic [31:0]  evt_vec;
   logic [31:0]  rise;
   logic [1:0]   ievt;
   mhcf_pkg::mhcf_msg_wr_s mw_q;

   wire in_config = (ctrl_state == mhcf_pkg::MHCF_DEFAULT_CONFIG) ||
                    (ctrl_state == mhcf_pkg::MHCF_CONFIG);
   wire state_clr = leave_config | enter_bringup;
   wire hdr_viol  = msg_wr_in.wr & msg_wr_in.hdr_target;
   wire sel_cf    = reg_addr == `MHCF_OFS_CONSTRAINT;
   wire sel_t0    = reg_addr == `MHCF_OFS_TXREQ_0_31;
   wire sel_t1    = reg_addr == `MHCF_OFS_TXREQ_32_63;
   wire sel_t2    = reg_addr == `MHCF_OFS_TXREQ_64_95;
   wire sel_t3    = reg_addr == `MHCF_OFS_TXREQ_96_127;
   wire sel_is    = reg_addr == `MHCF_OFS_IRQ_STATUS;
   wire sel_im    = reg_addr == `MHCF_OFS_IRQ_MASK;
   wire cf_clr    = reg_wr & sel_cf;
   wire [31:0] cf_wmask = cf_clr ? (reg_wdata & `MHCF_FLAG_MASK) : 32'h0; // R1 R18

   always_comb begin
      evt_vec = 32'h0;
      evt_vec[`MHCF_BIT_SKIP_A]   = evt.status_skip_chan_a;        // R4
      evt_vec[`MHCF_BIT_SKIP_B]   = evt.status_skip_chan_b;        // R5
      evt_vec[`MHCF_BIT_SEARCH_A] = evt.search_incomplete_chan_a;  // R6
      evt_vec[`MHCF_BIT_SEARCH_B] = evt.search_incomplete_chan_b;  // R7
      evt_vec[`MHCF_BIT_TRANS_A]  = evt.transient_access_fail_a;   // R8
      evt_vec[`MHCF_BIT_TRANS_B]  = evt.transient_access_fail_b;   // R9
      // hardware attempt and the flag both count, only outside config
      evt_vec[`MHCF_BIT_HDR_WR]   = (evt.header_write_blocked | hdr_viol) & ~in_config; // R10
   end

   // set wins over a same-cycle software clear; state clear beats both
   assign cflags_d = state_clr ? `MHCF_RST_CONSTRAINT :
                     (((cflags_q & ~cf_wmask) | evt_vec) & `MHCF_FLAG_MASK); // R1 R3 R18
   assign rise = evt_vec & ~cflags_q & ~{32{state_clr}};
   assign error_irq_handler_flag = |rise; // R12

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cflags_q <= `MHCF_RST_CONSTRAINT; // R2
      end else begin
         cflags_q <= cflags_d;
      end
   end

   // send request flags, one per buffer, cleared by state change too
   genvar gi;
   generate
      for (gi = 0; gi < `MHCF_NUM_BUF; gi = gi + 1) begin : g_buf
         wire in_range = gi < num_configured; // R16
         wire active   = in_range & buf_is_tx[gi]; // R15
         wire done_clr = send_done[gi] & buf_single_shot[gi]; // R14
         assign send_d[gi] = state_clr ? 1'b0 :
                             ((send_request_flag_q[gi] & ~done_clr) | (send_set[gi] & active));
         assign send_eligible[gi] = send_request_flag_q[gi] & active; // R15 R16
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         send_request_flag_q <= `MHCF_RST_TXREQ;
      end else begin
         send_request_flag_q <= send_d; // R13
      end
   end

   // header partition writes never pass on
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mw_q <= '0;
      end else begin
         mw_q    <= msg_wr_in;
         mw_q.wr <= msg_wr_in.wr & ~msg_wr_in.hdr_target; // R11
      end
   end
   assign msg_wr_out = mw_q;

   // interrupt: bit 0 constraint rise, bit 1 send completed
   assign ievt   = {|(send_done & send_request_flag_q), |rise};
   assign ists_d = (ists_q & ~((reg_wr & sel_is) ? reg_wdata[1:0] : 2'h0)) | ievt;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ists_q  <= 2'h0;
         imask_q <= 2'h0;
      end else begin
         ists_q <= ists_d;
         if (reg_wr & sel_im) begin
            imask_q <= reg_wdata[1:0];
         end
      end
   end
   assign irq = |(ists_q & imask_q);

   // read mux, unmapped reads zero
   wire [31:0] rd_mux = sel_cf ? cflags_q :
                        sel_t0 ? send_request_flag_q[31:0] :    // R17
                        sel_t1 ? send_request_flag_q[63:32] :   // R17
                        sel_t2 ? send_request_flag_q[95:64] :   // R17
                        sel_t3 ? send_request_flag_q[127:96] :  // R17
                        sel_is ? {30'h0, ists_q} :
                        sel_im ? {30'h0, imask_q} : 32'h0;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 32'h0;
      end
   end
   assign reg_rdata = rdata_q;

   AST_W1C_CLEARS: assert property (@(posedge clk_sys) disable iff (rst) // R1
      (cf_clr && reg_wdata[0] && !evt_vec[0] && !state_clr) |=> !cflags_q[0])
      else $error("flag not cleared by write one");
   AST_W0_KEEPS: assert property (@(posedge clk_sys) disable iff (rst) // R1
      (cf_clr && !reg_wdata[2] && cflags_q[2] && !state_clr) |=> cflags_q[2])
      else $error("flag lost on write zero");
   AST_STATE_CLR: assert property (@(posedge clk_sys) disable iff (rst) // R3
      state_clr |=> (cflags_q == 32'h0) && (send_request_flag_q == 128'h0))
      else $error("state change did not clear");
   AST_EVT_SETS: assert property (@(posedge clk_sys) disable iff (rst) // R4
      (evt.status_skip_chan_a && !state_clr) |=> cflags_q[0])
      else $error("channel a skip not flagged");
   AST_HDR_CFG: assert property (@(posedge clk_sys) disable iff (rst) // R10
      (in_config && !cflags_q[8]) |=> !cflags_q[8])
      else $error("header flag set in config");
   AST_HDR_BLOCK: assert property (@(posedge clk_sys) disable iff (rst) // R11
      (msg_wr_in.hdr_target) |=> !msg_wr_out.wr)
      else $error("header write passed");
   AST_RISE_IRQ: assert property (@(posedge clk_sys) disable iff (rst) // R12
      error_irq_handler_flag |=> (cflags_q != 32'h0) && ists_q[0])
      else $error("rise without flag");
   AST_SINGLE: assert property (@(posedge clk_sys) disable iff (rst) // R14
      (send_done[0] && buf_single_shot[0] && !(send_set[0] && send_eligible[0] == 1'b0 && 1'b0)
       && !(send_set[0] && num_configured != 8'h0 && buf_is_tx[0])) |=> !send_request_flag_q[0])
      else $error("single shot flag not cleared");
   AST_RANGE: assert property (@(posedge clk_sys) disable iff (rst) // R16
      (num_configured <= 8'h7f && !send_request_flag_q[127]) |=> !send_request_flag_q[127] || $past(num_configured) > 8'h7f)
      else $error("unconfigured flag set");
   AST_RSVD: assert property (@(posedge clk_sys) disable iff (rst) // R18
      (cflags_q & ~`MHCF_FLAG_MASK) == 32'h0)
      else $error("reserved bit set");
   AST_RD_T1: assert property (@(posedge clk_sys) disable iff (rst) // R17
      (reg_rd && sel_t1) |=> reg_rdata == $past(send_request_flag_q[63:32]))
      else $error("request word misplaced");
   AST_SKIP_B_SETS: assert property (@(posedge clk_sys) disable iff (rst) // R5
      (evt.status_skip_chan_b && !state_clr) |=> cflags_q[1])
      else $error("channel b skip not flagged");
   AST_SEARCH_A_SETS: assert property (@(posedge clk_sys) disable iff (rst) // R6
      (evt.search_incomplete_chan_a && !state_clr) |=> cflags_q[2])
      else $error("channel a search not flagged");
   AST_SEARCH_B_SETS: assert property (@(posedge clk_sys) disable iff (rst) // R7
      (evt.search_incomplete_chan_b && !state_clr) |=> cflags_q[3])
      else $error("channel b search not flagged");
   AST_TRANS_A_SETS: assert property (@(posedge clk_sys) disable iff (rst) // R8
      (evt.transient_access_fail_a && !state_clr) |=> cflags_q[4])
      else $error("channel a transient fail not flagged");
   AST_TRANS_B_SETS: assert property (@(posedge clk_sys) disable iff (rst) // R9
      (evt.transient_access_fail_b && !state_clr) |=> cflags_q[5])
      else $error("channel b transient fail not flagged");
   AST_HDR_RUN_SETS: assert property (@(posedge clk_sys) disable iff (rst) // R10
      (hdr_viol && !in_config && !state_clr) |=> cflags_q[8])
      else $error("header attempt not flagged");
   AST_RISE_PULSE: assert property (@(posedge clk_sys) disable iff (rst) // R12
      (evt.status_skip_chan_b && !cflags_q[1] && !state_clr) |-> error_irq_handler_flag)
      else $error("rising flag gave no irq pulse");
   AST_TX_ONLY: assert property (@(posedge clk_sys) disable iff (rst) // R15
      (send_set[5] && !buf_is_tx[5] && !send_request_flag_q[5]) |=> !send_request_flag_q[5])
      else $error("receive buffer took a request");
   AST_ELIG_RANGE: assert property (@(posedge clk_sys) disable iff (rst) // R16
      send_eligible[127] |-> (num_configured == 8'h80))
      else $error("unconfigured buffer eligible");
   AST_ELIG_TX: assert property (@(posedge clk_sys) disable iff (rst) // R15
      send_eligible[0] |-> (buf_is_tx[0] && send_request_flag_q[0]))
      else $error("eligible without tx request");
   AST_RD_IDLE: assert property (@(posedge clk_sys) disable iff (rst) // R13
      !reg_rd |=> (reg_rdata == 32'h0))
      else $error("read data outside read slot");
endmodule
`default_nettype wire

//--- verification/mhcf_status_bank_tb.sv
// self-checking bench of the handler status bank
`include "mhcf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module msg_handler_flags_txreq_status_tb_top;
   logic                    clk_sys, rst, reg_wr, reg_rd, leave_config, enter_bringup, eflag, irq;
   logic [11:0]             reg_addr;
   logic [31:0]             reg_wdata, reg_rdata, v;
   logic [127:0]            send_set, send_done, is_tx, one_shot, elig, exp;
   logic [7:0]              num_cfg;
   mhcf_pkg::mhcf_ctrl_e    st;
   mhcf_pkg::mhcf_events_s  evt;
   mhcf_pkg::mhcf_msg_wr_s  mw_in, mw_out;
   int                      err_count, num_checks;
   logic [6:0]              row_evt [7] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
   logic [31:0]             row_exp [7] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h20, 32'h100};
   mhcf_status_bank dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .leave_config(leave_config),
      .enter_bringup(enter_bringup), .ctrl_state(st), .evt(evt), .send_set(send_set),
      .send_done(send_done), .buf_is_tx(is_tx), .buf_single_shot(one_shot), .num_configured(num_cfg),
      .send_eligible(elig), .msg_wr_in(mw_in), .msg_wr_out(mw_out),
      .error_irq_handler_flag(eflag), .irq(irq));
   task chk(input string n, input logic [127:0] s, input logic [127:0] e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   // data stands only in the cycle after the strobe
   task rd(input logic [11:0] a);
      @(posedge clk_sys);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task pulse(input logic [6:0] e, input logic f);
      @(posedge clk_sys);
      evt <= e;
      #1 chk("eflag", eflag, f);
      @(posedge clk_sys);
      evt <= '0;
   endtask
   task results;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // whole run is about 150 cycles
   initial begin
      #100000;
      err_count++;
      results;
   end
   initial begin
      {rst, reg_wr, reg_rd, leave_config, enter_bringup} = 5'h10;
      reg_addr = '0; reg_wdata = '0; evt = '0; mw_in = '0; send_set = '0; send_done = '0;
      st = mhcf_pkg::MHCF_RUN; num_cfg = 8'h64; is_tx = ~128'h20; one_shot = 128'h1;
      err_count = 0; num_checks = 0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rd(`MHCF_OFS_CONSTRAINT); chk("rst_flags", v, 32'h0);
      chk("rst_irq", irq, 1'b0);
      for (int i = 0; i < 7; i++) begin
         pulse(row_evt[i], 1'b1);
         rd(`MHCF_OFS_CONSTRAINT); chk("flag_set", v, row_exp[i]);
         wr(`MHCF_OFS_CONSTRAINT, ~row_exp[i]);
         rd(`MHCF_OFS_CONSTRAINT); chk("w0_keep", v, row_exp[i]);
         wr(`MHCF_OFS_CONSTRAINT, row_exp[i]);
         rd(`MHCF_OFS_CONSTRAINT); chk("w1_clear", v, 32'h0);
      end
      // header attempt: write dropped, flag raised while running
      @(posedge clk_sys); mw_in <= '{1'b1, 7'h3, 1'b1, 32'h5a5a0f0f};
      @(posedge clk_sys); mw_in.hdr_target <= 1'b0;
      #1 chk("hdr_wr", mw_out.wr, 1'b0);
      @(posedge clk_sys); mw_in <= '0;
      #1 chk("data_wr", {mw_out.wr, mw_out.data}, {1'b1, 32'h5a5a0f0f});
      rd(`MHCF_OFS_CONSTRAINT); chk("hdr_flag", v, 32'h100);
      wr(`MHCF_OFS_CONSTRAINT, 32'hffffffff);
      for (int j = 0; j < 2; j++) begin
         @(posedge clk_sys);
         st <= j ? mhcf_pkg::MHCF_DEFAULT_CONFIG : mhcf_pkg::MHCF_CONFIG;
         pulse(7'h01, 1'b0);
         rd(`MHCF_OFS_CONSTRAINT); chk("cfg_hdr", v, 32'h0);
      end
      @(posedge clk_sys);
      st <= mhcf_pkg::MHCF_RUN;
      for (int j = 0; j < 2; j++) begin
         pulse(7'h7f, 1'b1);
         rd(`MHCF_OFS_CONSTRAINT); chk("all_flags", v, 32'h13f);
         @(posedge clk_sys); leave_config <= !j; enter_bringup <= j;
         @(posedge clk_sys); leave_config <= 1'b0; enter_bringup <= 1'b0;
         rd(`MHCF_OFS_CONSTRAINT); chk("state_clr", v, 32'h0);
      end
      chk("irq_masked", irq, 1'b0);
      wr(`MHCF_OFS_IRQ_MASK, 32'h1); chk("irq_on", irq, 1'b1);
      wr(`MHCF_OFS_IRQ_STATUS, 32'h1); chk("irq_off", irq, 1'b0);
      rd(12'h3f0); chk("unmapped", v, 32'h0);
      // bits 5, 100, 127 refused: receive buffer and beyond configured count
      @(posedge clk_sys); send_set <= 128'h80000018_00000000_00000100_00000021;
      @(posedge clk_sys); send_set <= '0;
      exp = 128'h00000008_00000000_00000100_00000001;
      for (int i = 0; i < 4; i++) begin
         rd(`MHCF_OFS_TXREQ_0_31 + 12'(i * 4)); chk("txreq", v, exp[i*32 +: 32]);
      end
      #1 chk("elig", elig, exp);
      @(posedge clk_sys); send_done <= 128'h100_00000001;
      @(posedge clk_sys); send_done <= '0;
      #1 chk("done_clr", elig, 128'h8_00000000_00000100_00000000);
      wr(`MHCF_OFS_TXREQ_32_63, 32'h0);
      rd(`MHCF_OFS_TXREQ_32_63); chk("ro", v, 32'h100);
      // mid-run hard reset with a flag and a request standing
      pulse(7'h40, 1'b1);
      @(posedge clk_sys); rst <= 1'b1;
      @(posedge clk_sys); rst <= 1'b0;
      rd(`MHCF_OFS_CONSTRAINT); chk("rst2_flags", v, 32'h0);
      rd(`MHCF_OFS_TXREQ_32_63); chk("rst2_txreq", v, 32'h0);
      results;
   end
endmodule
`default_nettype wire
